// *** shared/ccb_regs.vh ***
// Register map, field layout, reset values and timing constants for the protector config block
//
// Contract
// - 0x09 holds delay code [7:4], threshold [3:0]
// - Charge short delay is 60 us times (code+1)
// - Trip steps 5 mV low, 25 mV high range
// - Gain range bit selects threshold range
// - 0x0A holds mode [7:6], timeout [5:4], threshold [3:0]
// - Highest cell voltage decides balance start
// - Mode 01: always, timer, rearm after all below
// - Mode 10: only with charger, no timeout
// - Mode 11: charger, timeout, rearm by reconnect
// - Mode 00 disables the whole balancing function
// - Timer starts when bleeding actually begins
// - Timeout ends balancing; codes give 1,2,4,8 hours
// - Charger modes start on charger and threshold
// - Start threshold 3.9 V down 0.1 V per code
`ifndef CCB_REGS_VH
`define CCB_REGS_VH

`define CCB_ADDR_CHG_SHORT 8'h09
`define CCB_ADDR_BAL_CFG 8'h0A
`define CCB_CHG_SHORT_RESET 8'h00
`define CCB_BAL_CFG_RESET 8'h00

`define CCB_SCC_DELAY_MSB 7
`define CCB_SCC_DELAY_LSB 4
`define CCB_SCC_TRIP_MSB 3
`define CCB_SCC_TRIP_LSB 0
`define CCB_BAL_MODE_MSB 7
`define CCB_BAL_MODE_LSB 6
`define CCB_BAL_TMO_MSB 5
`define CCB_BAL_TMO_LSB 4
`define CCB_BAL_THR_MSB 3
`define CCB_BAL_THR_LSB 0

`define CCB_MODE_OFF 2'h0
`define CCB_MODE_ALWAYS 2'h1
`define CCB_MODE_CHG 2'h2
`define CCB_MODE_CHG_TMO 2'h3

// Clock rate and time figures; cycle counts derive from these
`define CCB_CLK_MHZ 10
`define CCB_SCC_STEP_US 60
`define CCB_SCC_STEP_CYCLES (`CCB_SCC_STEP_US * `CCB_CLK_MHZ)
`define CCB_TICKS_PER_SEC (`CCB_CLK_MHZ * 1000000)
`define CCB_HOUR_MIN 60
`define CCB_MIN_SEC 60
`define CCB_SEC_PER_HOUR (`CCB_HOUR_MIN * `CCB_MIN_SEC)

// Trip levels in mV (magnitudes, applied negative) and start threshold in mV
`define CCB_TRIP_LO_BASE 10
`define CCB_TRIP_LO_STEP 5
`define CCB_TRIP_HI_BASE 50
`define CCB_TRIP_HI_STEP 25
`define CCB_THR_TOP_MV 3900
`define CCB_THR_STEP_MV 100

`endif

// *** hw/ccb_timer.v ***
// Balance timeout timer: one second timebase and hour-multiple limit
`include "ccb_regs.vh"

module ccb_timer #(
	parameter [27:0] TICKS_PER_SEC = `CCB_TICKS_PER_SEC,
	parameter [14:0] SEC_PER_HOUR = `CCB_SEC_PER_HOUR
) (
	input wire i_clk,
	input wire i_srst,
	input wire i_clear,
	input wire i_run,
	input wire [1:0] i_code,
	output reg o_expired
);
	reg [27:0] tick_q;
	reg [14:0] sec_q;
	wire [14:0] limit;
	wire sec_pulse;

	// Whole hours only, so every selection is an exact multiple of one hour
	assign limit = SEC_PER_HOUR << i_code;
	assign sec_pulse = i_run && (tick_q == TICKS_PER_SEC - 28'h0000001);

	// Prescaler to a one-cycle enable per second
	always @(posedge i_clk)
	begin
		if (i_srst || i_clear || !i_run)
			tick_q <= 28'h0000000;
		else if (sec_pulse)
			tick_q <= 28'h0000000;
		else
			tick_q <= tick_q + 28'h0000001;
	end

	// Seconds counter; expiry holds until cleared by the next start
	always @(posedge i_clk)
	begin
		if (i_srst || i_clear)
		begin
			sec_q <= 15'h0000;
			o_expired <= 1'b0;
		end
		else if (sec_pulse && !o_expired)
		begin
			sec_q <= sec_q + 15'h0001;
			if (sec_q + 15'h0001 >= limit)
				o_expired <= 1'b1;
		end
	end
endmodule

// *** hw/ccb_top.v ***
// Charge short-circuit trip and automatic cell-balance controller
`include "ccb_regs.vh"

module ccb_top #(
	parameter N_CELLS = 10,
	parameter CELL_W = 13,
	parameter SENSE_W = 12,
	parameter [13:0] SCC_STEP_CYCLES = `CCB_SCC_STEP_CYCLES,
	parameter [27:0] TICKS_PER_SEC = `CCB_TICKS_PER_SEC,
	parameter [14:0] SEC_PER_HOUR = `CCB_SEC_PER_HOUR
) (
	input wire i_clk,
	input wire i_srst,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	output reg [7:0] o_reg_rdata,
	input wire i_sense_gain_range_bit,
	input wire signed [SENSE_W-1:0] i_sense_mv,
	input wire i_charger_present,
	input wire [N_CELLS*CELL_W-1:0] i_cell_mv,
	output reg o_charge_short_trip,
	output reg o_balancing,
	output reg o_balance_timeout,
	output reg [N_CELLS-1:0] o_bleed
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ACTIVE = 2'h1;
	localparam [1:0] S_DONE = 2'h2;

	// Level and threshold constants sized to the nets they feed, so nothing widens silently
	localparam [9:0] TRIP_LO_BASE = `CCB_TRIP_LO_BASE;
	localparam [9:0] TRIP_LO_STEP = `CCB_TRIP_LO_STEP;
	localparam [9:0] TRIP_HI_BASE = `CCB_TRIP_HI_BASE;
	localparam [9:0] TRIP_HI_STEP = `CCB_TRIP_HI_STEP;
	localparam [CELL_W-1:0] THR_TOP_MV = `CCB_THR_TOP_MV;
	localparam [CELL_W-1:0] THR_STEP_MV = `CCB_THR_STEP_MV;

	reg [7:0] charge_short_circuit_config_q;
	reg [7:0] cell_balance_config_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [13:0] scc_cnt_q;
	reg [CELL_W-1:0] max_cell;
	reg timer_clear;
	integer k;

	wire [3:0] charge_short_delay_code;
	wire [3:0] charge_short_threshold_code;
	wire [1:0] balance_enable_mode;
	wire [1:0] balance_timeout_code;
	wire [3:0] balance_start_threshold;
	wire [13:0] scc_delay_cycles;
	wire [9:0] trip_mag;
	wire signed [SENSE_W:0] trip_level;
	wire scc_over;
	wire [CELL_W-1:0] thr_mv;
	wire [N_CELLS-1:0] cell_above;
	wire any_above;
	wire timer_expired;

	// Field extraction
	assign charge_short_delay_code =
		charge_short_circuit_config_q[`CCB_SCC_DELAY_MSB:`CCB_SCC_DELAY_LSB];
	assign charge_short_threshold_code =
		charge_short_circuit_config_q[`CCB_SCC_TRIP_MSB:`CCB_SCC_TRIP_LSB];
	assign balance_enable_mode = cell_balance_config_q[`CCB_BAL_MODE_MSB:`CCB_BAL_MODE_LSB];
	assign balance_timeout_code = cell_balance_config_q[`CCB_BAL_TMO_MSB:`CCB_BAL_TMO_LSB];
	assign balance_start_threshold =
		cell_balance_config_q[`CCB_BAL_THR_MSB:`CCB_BAL_THR_LSB];

	// Register writes; both registers reset to zero, which leaves balancing off
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			charge_short_circuit_config_q <= `CCB_CHG_SHORT_RESET;
			cell_balance_config_q <= `CCB_BAL_CFG_RESET;
		end
		else if (i_reg_wr && i_reg_addr == `CCB_ADDR_CHG_SHORT)
			charge_short_circuit_config_q <= i_reg_wdata;
		else if (i_reg_wr && i_reg_addr == `CCB_ADDR_BAL_CFG)
			cell_balance_config_q <= i_reg_wdata;
	end

	// Registered read data, unmapped addresses read zero
	always @(posedge i_clk)
	begin
		if (i_srst)
			o_reg_rdata <= 8'h00;
		else if (i_reg_addr == `CCB_ADDR_CHG_SHORT)
			o_reg_rdata <= charge_short_circuit_config_q;
		else if (i_reg_addr == `CCB_ADDR_BAL_CFG)
			o_reg_rdata <= cell_balance_config_q;
		else
			o_reg_rdata <= 8'h00;
	end

	// Trip level: sense minus side relative to plus side, negative in charge
	assign trip_mag = i_sense_gain_range_bit ?
		(TRIP_HI_BASE + TRIP_HI_STEP * {6'h00, charge_short_threshold_code}) :
		(TRIP_LO_BASE + TRIP_LO_STEP * {6'h00, charge_short_threshold_code});
	assign trip_level = -$signed({{(SENSE_W-10){1'b0}}, 1'b0, trip_mag});
	assign scc_over = $signed({i_sense_mv[SENSE_W-1], i_sense_mv}) <= trip_level;
	assign scc_delay_cycles = SCC_STEP_CYCLES * ({10'h000, charge_short_delay_code} + 14'h0001);

	// Delay qualifier: the condition must hold for the whole delay; any gap restarts it
	always @(posedge i_clk)
	begin
		if (i_srst || !scc_over)
		begin
			scc_cnt_q <= 14'h0000;
			o_charge_short_trip <= 1'b0;
		end
		else if (scc_cnt_q + 14'h0001 >= scc_delay_cycles)
			o_charge_short_trip <= 1'b1;
		else
			scc_cnt_q <= scc_cnt_q + 14'h0001;
	end

	// Start threshold in mV
	assign thr_mv = THR_TOP_MV -
		THR_STEP_MV * {{(CELL_W-4){1'b0}}, balance_start_threshold};

	// Per-cell comparison against the start threshold
	genvar g;
	generate
		for (g = 0; g < N_CELLS; g = g + 1)
		begin : g_cell
			assign cell_above[g] = i_cell_mv[g*CELL_W +: CELL_W] >= thr_mv;
		end
	endgenerate

	// Highest cell decides the start
	always @*
	begin
		max_cell = {CELL_W{1'b0}};
		for (k = 0; k < N_CELLS; k = k + 1)
			if (i_cell_mv[k*CELL_W +: CELL_W] > max_cell)
				max_cell = i_cell_mv[k*CELL_W +: CELL_W];
	end
	assign any_above = max_cell >= thr_mv;

	// Balance sequencer
	always @*
	begin
		state_d = state_q;
		timer_clear = 1'b0;
		case (state_q)
			S_IDLE:
			begin
				if (balance_enable_mode == `CCB_MODE_ALWAYS && any_above)
				begin
					state_d = S_ACTIVE;
					timer_clear = 1'b1;
				end
				else if ((balance_enable_mode == `CCB_MODE_CHG ||
					balance_enable_mode == `CCB_MODE_CHG_TMO) &&
					i_charger_present && any_above)
				begin
					state_d = S_ACTIVE;
					timer_clear = 1'b1;
				end
			end
			S_ACTIVE:
			begin
				if (balance_enable_mode == `CCB_MODE_ALWAYS)
				begin
					if (timer_expired)
						state_d = S_DONE;
					else if (!any_above)
						state_d = S_IDLE;
				end
				else if (balance_enable_mode == `CCB_MODE_CHG)
				begin
					if (!i_charger_present)
						state_d = S_IDLE;
				end
				else if (!i_charger_present)
					state_d = S_IDLE;
				else if (timer_expired)
					state_d = S_DONE;
			end
			S_DONE:
			begin
				if (balance_enable_mode == `CCB_MODE_ALWAYS && !any_above)
					state_d = S_IDLE;
				else if (balance_enable_mode != `CCB_MODE_ALWAYS && !i_charger_present)
					state_d = S_IDLE;
			end
			default:
				state_d = S_IDLE;
		endcase
		// Mode 00 parks the sequencer in S_IDLE from any state; a change between other modes does not
		if (balance_enable_mode == `CCB_MODE_OFF)
			state_d = S_IDLE;
	end

	// State and registered outputs; bleed only cells at or above the threshold
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_q <= S_IDLE;
			o_balancing <= 1'b0;
			o_balance_timeout <= 1'b0;
			o_bleed <= {N_CELLS{1'b0}};
		end
		else
		begin
			state_q <= state_d;
			o_balancing <= state_d == S_ACTIVE;
			o_balance_timeout <= state_d == S_DONE;
			o_bleed <= (state_d == S_ACTIVE) ? cell_above : {N_CELLS{1'b0}};
		end
	end

	// Mode 10 never times out, so the timer only runs in the timed modes
	ccb_timer #(
		.TICKS_PER_SEC(TICKS_PER_SEC),
		.SEC_PER_HOUR(SEC_PER_HOUR)
	) u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_clear(timer_clear),
		.i_run(state_q == S_ACTIVE && balance_enable_mode != `CCB_MODE_CHG),
		.i_code(balance_timeout_code),
		.o_expired(timer_expired)
	);
endmodule

// *** verif/ccb_top_asserts.sv ***
// Port-level assertions for the charge short and cell balance block
module ccb_top_asserts #(
	parameter N_CELLS = 10,
	parameter CELL_W = 13,
	parameter SENSE_W = 12,
	parameter [13:0] SCC_STEP_CYCLES = 14'h0258
) (
	input wire i_clk,
	input wire i_srst,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire [7:0] o_reg_rdata,
	input wire i_sense_gain_range_bit,
	input wire signed [SENSE_W-1:0] i_sense_mv,
	input wire i_charger_present,
	input wire [N_CELLS*CELL_W-1:0] i_cell_mv,
	input wire o_charge_short_trip,
	input wire o_balancing,
	input wire o_balance_timeout,
	input wire [N_CELLS-1:0] o_bleed
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	reg [7:0] scc_q;
	reg [7:0] bal_q;
	int run_q;
	int due;
	int lvl;
	logic hot;
	logic any_hi;
	// Shadow registers written on the same edge as the design's own copies
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			scc_q <= 8'h00;
			bal_q <= 8'h00;
		end
		else if (i_reg_wr && i_reg_addr == 8'h09)
			scc_q <= i_reg_wdata;
		else if (i_reg_wr && i_reg_addr == 8'h0A)
			bal_q <= i_reg_wdata;
		run_q <= (hot && !i_srst) ? run_q + 1 : 0;
	end
	// Trip level, qualify time and start threshold from the shadow fields
	always @*
	begin
		lvl = i_sense_gain_range_bit ? 50 + 25 * scc_q[3:0] : 10 + 5 * scc_q[3:0];
		hot = i_sense_mv <= -lvl;
		due = SCC_STEP_CYCLES * (scc_q[7:4] + 1);
		any_hi = 1'b0;
		for (int i = 0; i < N_CELLS; i++)
			any_hi = any_hi | (i_cell_mv[i*CELL_W +: CELL_W] >= 3900 - 100 * bal_q[3:0]);
	end
	reg_back_a: assert property (
		(i_reg_wr && i_reg_addr inside {8'h09, 8'h0A}) ##1 ($stable(i_reg_addr) && !i_reg_wr)
		|=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("readback wrong");
	unmapped_rd_a: assert property (
		!(i_reg_addr inside {8'h09, 8'h0A}) |=> o_reg_rdata == 8'h00) else $error("unmapped");
	mode_off_a: assert property (
		bal_q[7:6] == 2'h0 |=> !o_balancing && !o_balance_timeout && o_bleed == '0)
		else $error("balancing while off");
	no_charger_a: assert property (
		bal_q[7] && !i_charger_present |=> !o_balancing) else $error("no charger");
	trip_clear_a: assert property (
		!hot |=> !o_charge_short_trip) else $error("trip without level");
	trip_early_a: assert property (
		$rose(o_charge_short_trip) |-> run_q >= due - 1) else $error("trip early");
	trip_late_a: assert property (
		run_q >= due + 2 |-> o_charge_short_trip) else $error("trip late");
	start_cause_a: assert property (
		$rose(o_balancing) |-> $past(any_hi)) else $error("start below threshold");
	cover property ($rose(o_charge_short_trip));
	cover property ($rose(o_balance_timeout));
	cover property (bal_q[7:6] == 2'h2 && o_balancing);
endmodule

// *** verif/tb_ccb_top.sv ***
// Self-checking bench for the charge short and cell balance block
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); \
		end \
	end
module tb_ccb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic gain = 1'b0;
	logic chg = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic signed [11:0] sense = 12'sh000;
	logic [129:0] cells;
	wire [7:0] rdata;
	wire trip;
	wire bal;
	wire tmo;
	wire [9:0] bleed;
	wire [2:0] st = {tmo, bal, trip};
	int mismatches = 0;
	int samples_checked = 0;
	int n;
	// Short counts: 4 cycles per delay step, one hour is 6 cycles
	ccb_top #(.SCC_STEP_CYCLES(14'h0004), .TICKS_PER_SEC(28'h0000002),
		.SEC_PER_HOUR(15'h0003)) u_ccb_top (.i_clk(clk), .i_srst(srst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata), .i_sense_gain_range_bit(gain),
		.i_sense_mv(sense), .i_charger_present(chg), .i_cell_mv(cells),
		.o_charge_short_trip(trip), .o_balancing(bal), .o_balance_timeout(tmo), .o_bleed(bleed));
	initial
		forever #50 clk = ~clk;
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data is registered, so look one edge after the address is taken
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1;
		`CHK(rdata, e);
	endtask
	// Bounded wait so a stuck output cannot hang the run
	task automatic wait_hi(input int w);
		n = 0;
		while (st[w] !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic cell3(input logic [12:0] v);
		@(posedge clk);
		cells[39 +: 13] <= v;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#2000000;
		mismatches++;
		tally_and_finish;
	end
	// Main sequence
	initial
	begin
		for (int i = 0; i < 10; i++)
			cells[i*13 +: 13] <= 13'h07D0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd_chk(8'h09, 8'h00);
		rd_chk(8'h0A, 8'h00);
		wr_reg(8'h09, 8'h23);
		wr_reg(8'h0A, 8'hC7);
		wr_reg(8'h0B, 8'hFF);
		rd_chk(8'h09, 8'h23);
		rd_chk(8'h0A, 8'hC7);
		rd_chk(8'h0B, 8'h00);
		$display("test regs done");
		// Just short of and at the level, low then high range
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			gain <= k[1];
			sense <= k[1] ? (k[0] ? -125 : -124) : (k[0] ? -25 : -24);
			repeat (20) @(posedge clk);
			#1;
			`CHK(trip, k[0]);
			@(posedge clk);
			sense <= 12'sh000;
			repeat (2) @(posedge clk);
			#1;
			`CHK(trip, 1'b0);
		end
		@(posedge clk);
		gain <= 1'b0;
		sense <= -12'sd25;
		wait_hi(0);
		`CHK(n inside {[11:14]}, 1'b1);
		@(posedge clk);
		sense <= 12'sh000;
		$display("test trip done");
		// Charger mode with timeout; restart only after a reconnect
		wr_reg(8'h0A, 8'hC0);
		@(posedge clk);
		chg <= 1'b1;
		cells[39 +: 13] <= 13'h0F3C;
		wait_hi(1);
		`CHK(bleed, 10'h008);
		wait_hi(2);
		`CHK(n inside {[5:8]}, 1'b1);
		repeat (10) @(posedge clk);
		#1;
		`CHK(bal, 1'b0);
		@(posedge clk);
		chg <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(tmo, 1'b0);
		@(posedge clk);
		chg <= 1'b1;
		wait_hi(1);
		`CHK(n < 5, 1'b1);
		// Charger-only mode never times out
		@(posedge clk);
		chg <= 1'b0;
		wr_reg(8'h0A, 8'h80);
		@(posedge clk);
		chg <= 1'b1;
		wait_hi(1);
		repeat (30) @(posedge clk);
		#1;
		`CHK(bal, 1'b1);
		@(posedge clk);
		chg <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(bal, 1'b0);
		// Always mode, every timeout code, lowest threshold at its edge
		for (int t = 0; t < 4; t++)
		begin
			cell3(13'h095F);
			wr_reg(8'h0A, {2'h1, t[1:0], 4'hF});
			repeat (3) @(posedge clk);
			#1;
			`CHK(bal, 1'b0);
			cell3(13'h0960);
			wait_hi(1);
			`CHK(n < 4, 1'b1);
			wait_hi(2);
			`CHK(n inside {[(6 << t) - 1:(6 << t) + 2]}, 1'b1);
			cell3(13'h095F);
			repeat (2) @(posedge clk);
			#1;
			`CHK(tmo, 1'b0);
		end
		// Code 00 stops balancing already in progress
		wr_reg(8'h0A, 8'h40);
		cell3(13'h0F3C);
		wait_hi(1);
		wr_reg(8'h0A, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		`CHK({bal, bleed}, 11'h000);
		$display("test balance done");
		tally_and_finish;
	end
endmodule
bind ccb_top ccb_top_asserts #(.N_CELLS(N_CELLS), .CELL_W(CELL_W), .SENSE_W(SENSE_W),
	.SCC_STEP_CYCLES(SCC_STEP_CYCLES)) u_ccb_top_asserts (.i_clk(i_clk), .i_srst(i_srst),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.o_reg_rdata(o_reg_rdata), .i_sense_gain_range_bit(i_sense_gain_range_bit),
	.i_sense_mv(i_sense_mv), .i_charger_present(i_charger_present), .i_cell_mv(i_cell_mv),
	.o_charge_short_trip(o_charge_short_trip), .o_balancing(o_balancing),
	.o_balance_timeout(o_balance_timeout), .o_bleed(o_bleed));
